//--- sim/event_triggered_transfer_controller_tb.sv
// bench: both ends joined by the link, a memory model, wishbone master
// assumes the design files and the checker compiled first
`timescale 1ns/100ps

module event_triggered_transfer_controller_tb;
    import xfer_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] ev = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] q, rdata, dat_o, maddr, mwdata, d_irq, d_clr;
    logic ack, mreq, mwe, sw_irq;
    logic [1:0] msize, wsize;
    logic [7:0] clr, irq;
    logic [31:0] mem [logic [31:0]];
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_rd, n_wr, n_busy;
    xfer_link_if link();

    transfer_controller u_transfer_controller (.clk_i(clk_i),
        .rst_i(rst_i), .link(link), .mem_req_o(mreq), .mem_we_o(mwe),
        .mem_size_o(msize), .mem_addr_o(maddr), .mem_wdata_o(mwdata),
        .mem_rdata_i(rdata));
    xfer_system_end u_xfer_system_end (.clk_i(clk_i), .rst_i(rst_i),
        .link(link), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .src_event_i(ev), .src_clear_o(clr),
        .src_irq_o(irq), .sw_irq_o(sw_irq));
    xfer_link_chk u_xfer_link_chk (.clk_i(clk_i), .rst_i(rst_i),
        .act_req(link.act_req), .sw_req(link.sw_req), .busy(link.busy),
        .done(link.done), .done_sw(link.done_sw),
        .done_src(link.done_src), .done_irq(link.done_irq));

    // unwritten places return a value that differs per address
    function automatic logic [31:0] rd(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : ~a;
    endfunction
    assign rdata = mreq ? rd(maddr) : 32'hffffffff;

    always #20 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles++;
        if (link.busy === 1'b1) n_busy++;
        if (mreq === 1'b1 && mwe === 1'b1) begin
            if (n_wr == 0) wsize = msize;
            n_wr++;
            mem[maddr] = mwdata;
        end else if (mreq === 1'b1) n_rd++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("ack delay", 32'h2, n);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic desc(input logic [15:0] lo, md, cnt,
                        input logic [31:0] s3, sa, da);
        logic [31:0] b;
        b = {16'h0001, lo};
        mem[b] = {md, cnt};
        mem[b + 32'h4] = s3;
        mem[b + 32'h8] = sa;
        mem[b + 32'hc] = da;
    endtask

    task automatic fire(input logic [7:0] m);
        n_rd = 0;
        n_wr = 0;
        n_busy = 0;
        if (m != 8'h00) begin
            @(posedge clk_i);
            ev <= m;
            @(posedge clk_i);
            ev <= 8'h00;
        end
    endtask

    task automatic finish_act(input int r, w, input logic i);
        int n;
        n = 0;
        while (link.done !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk("done seen", 32'h1, {31'h0, link.done});
        d_irq = {31'h0, link.done_irq};
        @(posedge clk_i);
        d_clr = {24'h0, clr};
        chk("read states", r, n_rd);
        chk("write states", w, n_wr);
        chk("busy cycles", r + w + 2, n_busy);
        chk("done irq", {31'h0, i}, d_irq);
    endtask

    task automatic t_normal();
        mem[32'h2000] = 32'h0000005c;
        desc(16'h0100, 16'h2000, 16'h0002, 0, 32'h2000, 32'h3000);
        fire(8'h01);
        finish_act(6, 4, 1'b0);
        chk("clear", 32'h01, d_clr);
        chk("data", 32'h5c, mem[32'h3000] & 32'hff);
        chk("count", 32'h20000001, mem[32'h10100]);
        chk("dest", 32'h3001, mem[32'h1010c]);
        chk("src", 32'h2000, mem[32'h10108]);
        rdchk("pending", 8'h04, 32'h0);
        fire(8'h01);
        finish_act(6, 4, 1'b1);
        chk("clear", 32'h0, d_clr);
        rdchk("enable", 8'h00, 32'h0e);
        rdchk("pending", 8'h04, 32'h01);
        chk("cpu irq", 32'h01, {24'h0, irq});
        wb(1'b1, 8'h04, 4'hf, 32'h1);
        wb(1'b1, 8'h00, 4'hf, 32'h0f);
        chk("cpu irq", 32'h0, {24'h0, irq});
        $display("test normal done");
    endtask

    task automatic t_states();
        logic [31:0] sa [7] = '{32'h2000, 32'hffff8000, 32'hffffbffe,
            32'hffff8000, 32'hffff8600, 32'hffff87fc, 32'hffffc000};
        logic [31:0] da [7] = '{32'hffff8600, 32'h3000, 32'h3000,
            32'h3000, 32'h3000, 32'hffff8000, 32'h3000};
        logic [7:0] sz [7] = '{8'h2, 8'h0, 8'h1, 8'h2, 8'h0, 8'h2, 8'h0};
        int rs [7] = '{1, 2, 2, 4, 3, 6, 1};
        int ws [7] = '{6, 1, 1, 1, 1, 4, 1};
        for (int k = 0; k < 7; k++) begin
            desc(16'h0120, {6'h08, sz[k][1:0], 8'h0}, 16'h0064, 0,
                 sa[k], da[k]);
            fire(8'h02);
            finish_act(5 + rs[k], 3 + ws[k], 1'b0);
            chk("size", {30'h0, sz[k][1:0]}, {30'h0, wsize});
        end
        $display("test states done");
    endtask

    task automatic t_modes();
        desc(16'h0140, 16'h2400, 16'h0201, 32'h4000, 32'h2000, 32'h4001);
        fire(8'h04);
        finish_act(6, 4, 1'b0);
        chk("reload", 32'h24000202, mem[32'h10140]);
        chk("area", 32'h4000, mem[32'h1014c]);
        chk("data", 32'h5c, mem[32'h4001] & 32'hff);
        desc(16'h0160, 16'h2800, 16'h0001, 32'h3, 32'h2000, 32'h5000);
        fire(8'h08);
        finish_act(8, 6, 1'b1);
        chk("block area", 32'h5000, mem[32'h1016c]);
        chk("last item", 32'h5c, mem[32'h5002] & 32'hff);
        chk("block count", 32'h28000000, mem[32'h10160]);
        desc(16'h0100, 16'h2040, 16'h0005, 0, 32'h2000, 32'h3000);
        desc(16'h0110, 16'h2000, 16'h0005, 0, 32'h2000, 32'h3100);
        fire(8'h01);
        finish_act(11, 8, 1'b0);
        chk("chained", 32'h3101, mem[32'h1011c]);
        $display("test modes done");
    endtask

    task automatic t_soft();
        mem[32'h410] = 32'h0200;
        desc(16'h0200, 16'h2000, 16'h0005, 0, 32'h2000, 32'h3000);
        rdchk("trigger", 8'h08, 32'h0);
        fire(8'h00);
        wb(1'b1, 8'h08, 4'h3, 32'h110);
        finish_act(6, 4, 1'b0);
        rdchk("trigger", 8'h08, 32'h010);
        desc(16'h0200, 16'h2000, 16'h0001, 0, 32'h2000, 32'h3000);
        fire(8'h00);
        wb(1'b1, 8'h08, 4'h3, 32'h110);
        finish_act(6, 4, 1'b1);
        rdchk("trigger", 8'h08, 32'h310);
        chk("sw irq", 32'h1, {31'h0, sw_irq});
        wb(1'b1, 8'h08, 4'h2, 32'h0);
        rdchk("trigger", 8'h08, 32'h010);
        chk("sw irq", 32'h0, {31'h0, sw_irq});
        $display("test software done");
    endtask

    initial begin
        for (int s = 0; s < 4; s++) begin
            mem[32'h400 + 2 * s] = 32'h0100 + 32 * s;
        end
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("enable", 8'h00, 32'h0);
        rdchk("pending", 8'h04, 32'h0);
        rdchk("base", 8'h0c, 32'h0);
        wb(1'b1, 8'h10, 4'hf, 32'hffffffff);
        rdchk("unmapped", 8'h10, 32'h0);
        wb(1'b1, 8'h0c, 4'hf, 32'h1);
        wb(1'b1, 8'h00, 4'hf, 32'h0f);
        t_normal();
        t_states();
        t_modes();
        t_soft();
        final_report();
    end
endmodule

//--- sim/xfer_link_chk.sv
// checker on the link between the controller and the system end
// assumes the interface signals wired in by name from the bench
`timescale 1ns/100ps

module xfer_link_chk (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic [7:0] act_req, // pending and enabled sources
    input wire logic sw_req, // software activation armed
    input wire logic busy, // controller working
    input wire logic done, // end of activation
    input wire logic done_sw, // activation was software
    input wire logic [2:0] done_src, // source index
    input wire logic done_irq // activation interrupts the cpu
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    done_one_pulse_a: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    src_hold_a: assert property (busy && !done |=>
        $stable(done_src) && $stable(done_sw))
        else $error("source changed during activation");
    busy_cause_a: assert property ($rose(busy) |->
        $past(act_req) != 8'h00 || $past(sw_req))
        else $error("busy without a request");
    min_length_a: assert property ($rose(busy) |-> !done [*8])
        else $error("activation shorter than its accesses");
    done_bound_a: assert property ($rose(busy) |-> ##[1:600] done)
        else $error("activation never ends");
    busy_drop_a: assert property (done |=> !busy)
        else $error("busy after done");
    busy_hold_a: assert property (busy && !done |=> busy)
        else $error("busy dropped before done");
    src_match_a: assert property (done && !done_sw |->
        act_req[done_src])
        else $error("serviced source not requesting");

    cover property (done && done_irq);
    cover property (done && !done_irq);
    cover property (done && done_sw);
endmodule

//--- verilog/transfer_controller.sv
// transfer controller: vector fetch, descriptor read, data moves, write-back
// assumes a memory port whose read data is valid in an access's last state
//
// Functional notes
// - descriptor read 4 cycles, write-back 3 cycles
// - vector read, seven descriptor accesses, one internal
// - block mode moves block length items
// - time is vector, chained transfers, internal step
// - two-state peripherals 2 states, longword 4
// - three-state peripherals 3 states, longword 6
// - enabled source activates controller, not CPU
// - no irq: clear source; irq: clear enable
// - CPU clears source, re-enables for more
// - software checks trigger bit is zero first
// - software writes trigger bit with vector byte
// - trigger bit cleared unless completion irq raised
// - CPU clears trigger bit, sets for more
// - software sets descriptors, base, vector table
// - decode source, destination, mode, size, chain fields
// - serviced receive source gets its flag cleared
// - count zero: clear enable, pass interrupt on
// - descriptors never target controller registers
// - other DMA never targets controller registers
// - enable bits set only when channels idle
// - normal mode: one item, count down, irq
// - repeat mode reloads address and count
// - block mode restores area address each block
// - descriptor slot layout depends on mode
`timescale 1ns/100ps
`include "xfer_defines.svh"

module transfer_controller
    import xfer_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, active high
    xfer_link_if.ctrl link, // to the system end
    output logic mem_req_o, // access in progress
    output logic mem_we_o, // access is a write
    output logic [1:0] mem_size_o, // byte, word or longword
    output logic [31:0] mem_addr_o, // access address
    output logic [31:0] mem_wdata_o, // write data
    input wire logic [31:0] mem_rdata_i // read data
);

    ctrl_regs_t q;
    ctrl_regs_t n;

    function automatic logic [2:0] acc_states(input logic [31:0] a,
                                              input logic [1:0] sz);
        logic lng;
        lng = (sz == `SZ_LONG);
        if (a >= `P3_BASE && a <= `P3_LIMIT) begin
            acc_states = lng ? `ST_P3_LONG : `ST_P3;
        end else if (a >= `P2_BASE && a <= `P2_LIMIT) begin
            acc_states = lng ? `ST_P2_LONG : `ST_P2;
        end else begin
            acc_states = `ST_FAST;
        end
    endfunction

    function automatic ctrl_regs_t issue(input ctrl_regs_t s,
                                         input logic [31:0] a,
                                         input logic we,
                                         input logic [1:0] sz,
                                         input logic [31:0] wd);
        ctrl_regs_t r;
        r = s;
        r.mem_req = 1'b1;
        r.mem_we = we;
        r.mem_addr = a;
        r.mem_size = sz;
        r.mem_wdata = wd;
        r.acc_cnt = acc_states(a, sz) - 3'h1;
        return r;
    endfunction

    function automatic logic [31:0] next_addr(input logic [31:0] a,
                                              input logic [1:0] am,
                                              input logic [1:0] sz);
        logic [31:0] inc;
        inc = 32'h00000001 << sz;
        if (!am[1]) begin
            next_addr = a;
        end else if (!am[0]) begin
            next_addr = a + inc;
        end else begin
            next_addr = a - inc;
        end
    endfunction

    function automatic logic [31:0] desc_ofs(input logic [1:0] st);
        unique case (st)
            2'h0: desc_ofs = `DESC_MODE;
            2'h1: desc_ofs = `DESC_SLOT3;
            2'h2: desc_ofs = `DESC_SAR;
            2'h3: desc_ofs = `DESC_DAR;
        endcase
    endfunction

    function automatic logic [2:0] pick(input logic [7:0] req);
        logic [2:0] p;
        p = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                p = 3'(i);
            end
        end
        return p;
    endfunction

    logic fin;
    logic [1:0] md;
    logic [1:0] sz;
    logic area_side_select;
    logic last;
    logic [2:0] src_sel;

    always_comb begin
        n = q;
        fin = q.mem_req && (q.acc_cnt == 3'h0);
        md = q.mode[`MW_MD_HI:`MW_MD_LO];
        sz = q.mode[`MW_SZ_HI:`MW_SZ_LO];
        area_side_select = q.mode[`MW_DTS];
        last = (q.count == 16'h0001);
        src_sel = pick(link.act_req);
        if (q.mem_req && !fin) begin
            n.acc_cnt = q.acc_cnt - 3'h1;
        end
        if (fin) begin
            n.mem_req = 1'b0;
        end
        unique case (q.fsm)
            ST_IDLE: begin
                n.irq = 1'b0;
                if (|link.act_req) begin
                    n.is_sw = 1'b0;
                    n.src = src_sel;
                    n = issue(n, `VEC_BASE + {28'h0, src_sel, 1'b0},
                              1'b0, `SZ_WORD, 32'h0);
                    n.fsm = ST_VEC;
                end else if (link.sw_req) begin
                    n.is_sw = 1'b1;
                    n.src = 3'h0;
                    n = issue(n, `VEC_BASE + {24'h0, link.sw_vec},
                              1'b0, `SZ_WORD, 32'h0);
                    n.fsm = ST_VEC;
                end
            end
            ST_VEC: begin
                if (fin) begin
                    n.desc_addr = {link.base_upper, mem_rdata_i[15:0]};
                    n.step = 2'h0;
                    n = issue(n, n.desc_addr, 1'b0, `SZ_LONG, 32'h0);
                    n.fsm = ST_DRD;
                end
            end
            ST_DRD: begin
                if (fin) begin
                    unique case (q.step)
                        2'h0: begin
                            n.mode = mem_rdata_i[31:16];
                            n.count = mem_rdata_i[15:0];
                        end
                        2'h1: n.slot3 = mem_rdata_i;
                        2'h2: n.sar = mem_rdata_i;
                        2'h3: n.dar = mem_rdata_i;
                    endcase
                    if (q.step == 2'h3) begin
                        n.blk_left = q.slot3[15:0];
                        n.area_init = area_side_select ? q.sar : mem_rdata_i;
                        n = issue(n, q.sar, 1'b0, sz, 32'h0);
                        n.fsm = ST_RD;
                    end else begin
                        n.step = q.step + 2'h1;
                        n = issue(n, q.desc_addr + desc_ofs(n.step),
                                  1'b0, `SZ_LONG, 32'h0);
                    end
                end
            end
            ST_RD: begin
                if (fin) begin
                    n = issue(n, q.dar, 1'b1, sz, mem_rdata_i);
                    n.fsm = ST_WR;
                end
            end
            ST_WR: begin
                if (fin) begin
                    n.sar = next_addr(q.sar,
                        q.mode[`MW_SM_HI:`MW_SM_LO], sz);
                    n.dar = next_addr(q.dar,
                        q.mode[`MW_DM_HI:`MW_DM_LO], sz);
                    if (md == `MD_BLOCK && q.blk_left != 16'h0001) begin
                        n.blk_left = q.blk_left - 16'h0001;
                        n = issue(n, n.sar, 1'b0, sz, 32'h0);
                        n.fsm = ST_RD;
                    end else begin
                        if (md == `MD_REPEAT) begin
                            if (q.count[7:0] == 8'h01) begin
                                n.count[7:0] = q.count[15:8];
                                if (area_side_select) begin
                                    n.sar = q.slot3;
                                end else begin
                                    n.dar = q.slot3;
                                end
                            end else begin
                                n.count[7:0] = q.count[7:0] - 8'h01;
                            end
                            n.irq = q.irq | q.mode[`MW_IRQ_SELECT];
                        end else begin
                            if (md == `MD_BLOCK) begin
                                if (area_side_select) begin
                                    n.sar = q.area_init;
                                end else begin
                                    n.dar = q.area_init;
                                end
                            end
                            n.count = q.count - 16'h0001;
                            n.irq = q.irq | q.mode[`MW_IRQ_SELECT] | last;
                        end
                        n.step = 2'h0;
                        n = issue(n, q.desc_addr + `DESC_MODE, 1'b1,
                                  `SZ_LONG, {q.mode, n.count});
                        n.fsm = ST_DWR;
                    end
                end
            end
            ST_DWR: begin
                if (fin) begin
                    if (q.step == 2'h2) begin
                        if (q.mode[`MW_CHAIN_ENABLE]) begin
                            n.desc_addr = q.desc_addr + `DESC_STRIDE;
                            n.step = 2'h0;
                            n = issue(n, n.desc_addr, 1'b0,
                                      `SZ_LONG, 32'h0);
                            n.fsm = ST_DRD;
                        end else begin
                            n.fsm = ST_INT;
                        end
                    end else begin
                        n.step = q.step + 2'h1;
                        n = issue(n, q.desc_addr + desc_ofs(n.step + 2'h1),
                                  1'b1, `SZ_LONG,
                                  (q.step == 2'h0) ? q.sar : q.dar);
                    end
                end
            end
            ST_INT: n.fsm = ST_DONE;
            ST_DONE: n.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.fsm <= ST_IDLE;
        end else begin
            q <= n;
        end
    end

    assign link.busy = (q.fsm != ST_IDLE);
    assign link.done = (q.fsm == ST_DONE);
    assign link.done_sw = q.is_sw;
    assign link.done_src = q.src;
    assign link.done_irq = q.irq;
    assign mem_req_o = q.mem_req;
    assign mem_we_o = q.mem_we;
    assign mem_size_o = q.mem_size;
    assign mem_addr_o = q.mem_addr;
    assign mem_wdata_o = q.mem_wdata;

endmodule

//--- verilog/xfer_defines.svh
// constants for the event triggered transfer controller and its system end
// assumes inclusion by bare name from the package and both ends
`ifndef XFER_DEFINES_SVH
`define XFER_DEFINES_SVH

`define NUM_SRC 8
`define VEC_BASE 32'h00000400
// descriptor slots: mode word and count share the first longword
`define DESC_MODE 32'h00000000
`define DESC_SLOT3 32'h00000004
`define DESC_SAR 32'h00000008
`define DESC_DAR 32'h0000000c
`define DESC_STRIDE 32'h00000010

// mode word field positions
`define MW_SM_HI 15
`define MW_SM_LO 14
`define MW_DM_HI 13
`define MW_DM_LO 12
`define MW_MD_HI 11
`define MW_MD_LO 10
`define MW_SZ_HI 9
`define MW_SZ_LO 8
`define MW_DTS 7
`define MW_CHAIN_ENABLE 6
`define MW_IRQ_SELECT 5

`define MD_NORMAL 2'h0
`define MD_REPEAT 2'h1
`define MD_BLOCK 2'h2
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2

// access state counts per target class
`define ST_FAST 3'h1
`define ST_P2 3'h2
`define ST_P2_LONG 3'h4
`define ST_P3 3'h3
`define ST_P3_LONG 3'h6
`define P3_BASE 32'hffff8600
`define P3_LIMIT 32'hffff87ff
`define P2_BASE 32'hffff8000
`define P2_LIMIT 32'hffffbfff

// system end register map (byte addresses)
`define REG_ENABLE 8'h00
`define REG_PENDING 8'h04
`define REG_SWCS 8'h08
`define REG_BASE 8'h0c
`define SWCS_TRIG 8
`define SWCS_IRQ 9
`define SWCS_BUSY 10
`define RST_ENABLE 8'h00
`define RST_BASE 16'h0000

`endif

//--- verilog/xfer_link_if.sv
// link between the transfer controller and the system end
// assumes both ends on the same clock
`timescale 1ns/100ps

interface xfer_link_if;
    logic [7:0] act_req;
    logic sw_req;
    logic [7:0] sw_vec;
    logic [15:0] base_upper;
    logic busy;
    logic done;
    logic done_sw;
    logic [2:0] done_src;
    logic done_irq;

    modport ctrl (
        input act_req, sw_req, sw_vec, base_upper,
        output busy, done, done_sw, done_src, done_irq
    );
    modport sys (
        output act_req, sw_req, sw_vec, base_upper,
        input busy, done, done_sw, done_src, done_irq
    );
endinterface

//--- verilog/xfer_pkg.sv
// types shared by the transfer controller and its system end
// assumes xfer_defines.svh on the include path
`include "xfer_defines.svh"

package xfer_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VEC,
        ST_DRD,
        ST_RD,
        ST_WR,
        ST_DWR,
        ST_INT,
        ST_DONE
    } ctrl_state_t;

    typedef struct packed {
        ctrl_state_t fsm;
        logic [2:0] acc_cnt;
        logic [1:0] step;
        logic is_sw;
        logic [2:0] src;
        logic irq;
        logic [31:0] desc_addr;
        logic [15:0] mode;
        logic [15:0] count;
        logic [31:0] slot3;
        logic [31:0] sar;
        logic [31:0] dar;
        logic [31:0] area_init;
        logic [15:0] blk_left;
        logic mem_req;
        logic mem_we;
        logic [1:0] mem_size;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
    } ctrl_regs_t;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] pending;
        logic sw_trig;
        logic [7:0] sw_vec;
        logic sw_armed;
        logic sw_irq;
        logic [15:0] base;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] clr;
    } sys_regs_t;

endpackage

//--- verilog/xfer_system_end.sv
// system end: source enables, pending sources, software trigger, base
// assumes classic wishbone from software and source events on this clock
`timescale 1ns/100ps
`include "xfer_defines.svh"

module xfer_system_end
    import xfer_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, active high
    xfer_link_if.sys link, // to the transfer controller
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [7:0] src_event_i, // source request pulses
    output logic [7:0] src_clear_o, // source flag clear pulses
    output logic [7:0] src_irq_o, // sources passed to the cpu
    output logic sw_irq_o // software completion interrupt
);

    sys_regs_t q;
    sys_regs_t n;

    function automatic logic [7:0] lane(input logic [7:0] old,
                                        input logic [7:0] nv,
                                        input logic en);
        return en ? nv : old;
    endfunction

    logic take;
    logic wr;
    logic [7:0] done_bit;
    logic [7:0] sw_clr;

    always_comb begin
        n = q;
        take = wb_cyc_i && wb_stb_i && !q.ack;
        wr = take && wb_we_i;
        done_bit = 8'h00;
        sw_clr = 8'h00;
        n.ack = take;
        n.clr = 8'h00;
        if (link.done && !link.done_sw) begin
            done_bit[link.done_src] = 1'b1;
        end
        if (wr && wb_adr_i == `REG_PENDING && wb_sel_i[0]) begin
            sw_clr = wb_dat_i[7:0];
        end
        // hardware clear of the enable, software set of it wins
        if (link.done_irq) begin
            n.enable = q.enable & ~done_bit;
        end else begin
            n.clr = done_bit;
        end
        n.pending = (q.pending & ~sw_clr & ~n.clr) | src_event_i;
        if (wr && wb_adr_i == `REG_ENABLE) begin
            n.enable = lane(n.enable, wb_dat_i[7:0], wb_sel_i[0]);
        end
        if (wr && wb_adr_i == `REG_BASE) begin
            n.base[7:0] = lane(q.base[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            n.base[15:8] = lane(q.base[15:8], wb_dat_i[15:8],
                                wb_sel_i[1]);
        end
        if (wr && wb_adr_i == `REG_SWCS) begin
            n.sw_vec = lane(q.sw_vec, wb_dat_i[7:0], wb_sel_i[0]);
            if (wb_sel_i[1]) begin
                n.sw_trig = wb_dat_i[`SWCS_TRIG];
                n.sw_armed = wb_dat_i[`SWCS_TRIG];
                n.sw_irq = 1'b0;
            end
        end
        if (link.done && link.done_sw) begin
            n.sw_armed = 1'b0;
            if (link.done_irq) begin
                n.sw_irq = 1'b1;
            end else begin
                n.sw_trig = 1'b0;
            end
        end
        if (take) begin
            unique case (wb_adr_i)
                `REG_ENABLE: n.rdat = {24'h0, q.enable};
                `REG_PENDING: n.rdat = {24'h0, q.pending};
                `REG_SWCS: n.rdat = {21'h0, link.busy, q.sw_irq,
                                     q.sw_trig, q.sw_vec};
                `REG_BASE: n.rdat = {16'h0, q.base};
                default: n.rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.enable <= `RST_ENABLE;
            q.base <= `RST_BASE;
        end else begin
            q <= n;
        end
    end

    // registered pending, enable and trigger state is offered to the controller, idle or busy
    assign link.act_req = q.pending & q.enable;
    assign link.sw_req = q.sw_armed;
    assign link.sw_vec = q.sw_vec;
    assign link.base_upper = q.base;
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign src_clear_o = q.clr;
    assign src_irq_o = q.pending & ~q.enable;
    assign sw_irq_o = q.sw_irq;

endmodule
